// >>> hw/bdmc_pkg.sv
package bdmc_pkg;
  // Bank geometry
  localparam int BANKS = 32;
  localparam int BANK_BYTES = 128;
  localparam int RAM_BYTES = 80;
  localparam int COMMON_BYTES = 16;
  localparam int RAM_TOTAL = BANKS * RAM_BYTES;

  // Core register offsets, same in every bank
  localparam logic [6:0] OFF_IND_PORT0 = 7'h00;
  localparam logic [6:0] OFF_IND_PORT1 = 7'h01;
  localparam logic [6:0] OFF_PC_LOW = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PTR0L = 7'h04;
  localparam logic [6:0] OFF_PTR0H = 7'h05;
  localparam logic [6:0] OFF_PTR1L = 7'h06;
  localparam logic [6:0] OFF_PTR1H = 7'h07;
  localparam logic [6:0] OFF_BANKSEL = 7'h08;
  localparam logic [6:0] OFF_WACC = 7'h09;
  localparam logic [6:0] OFF_PCLATCH = 7'h0A;
  localparam logic [6:0] OFF_INTCTL = 7'h0B;

  // Region boundaries inside a bank
  localparam logic [6:0] OFF_PER_HI = 7'h1F;
  localparam logic [6:0] OFF_RAM_LO = 7'h20;
  localparam logic [6:0] OFF_COM_LO = 7'h70;

  // Banks holding pin remap and logic cell registers
  localparam logic [4:0] REMAP_BANK_LO = 5'h1B;
  localparam logic [4:0] REMAP_BANK_HI = 5'h1D;

  // Flag bit positions
  localparam int ST_TIMEOUT = 4;
  localparam int ST_PWRDN = 3;
  localparam int ST_Z = 2;
  localparam int ST_DIGIT = 1;
  localparam int ST_C = 0;

  // Program memory select bit inside pointer high byte
  localparam int PTR_PM_BIT = 7;

  // Reset values and write masks
  localparam logic [4:0] RST_STATUS = 5'h18;
  localparam logic [7:0] RST_INTCTL = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] MASK_INTCTL = 8'hC1;

  // Operations that produce the written value and flags
  typedef enum logic [3:0] {
    OP_PASS = 4'h0, OP_SWAP = 4'h1, OP_CLR = 4'h2, OP_ADD = 4'h3, OP_SUB = 4'h4,
    OP_AND = 4'h5, OP_IOR = 4'h6, OP_XOR = 4'h7, OP_RLC = 4'h8, OP_RRC = 4'h9
  } bdmc_op_e;

  typedef enum logic {ST_IDLE = 1'b0, ST_PMWAIT = 1'b1} bdmc_state_e;
endpackage

// >>> hw/bdmc_regs.sv
`timescale 1ns/1ps
module bdmc_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Access request from instruction execution
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqToW,
  input wire logic [6:0] reqOffset,
  input bdmc_pkg::bdmc_op_e reqOp,
  input wire logic [7:0] reqOpA,
  input wire logic [7:0] reqOpB,
  // Answer to the request
  output logic rspValid,
  output logic [7:0] rspData,
  // Program memory read port
  output logic pmRead,
  output logic [14:0] pmAddr,
  input wire logic [13:0] pmData,
  // Peripheral control register window
  output logic perSel,
  output logic perWrite,
  output logic [11:0] perAddr,
  output logic [7:0] perWrData,
  input wire logic [7:0] perRdData,
  // Reset cause events
  input wire logic dogClearEvt,
  input wire logic sleepEvt,
  input wire logic dogTimeoutEvt,
  // Core register views
  output logic [7:0] accOut,
  output logic [4:0] bankOut,
  output logic [7:0] pcLowOut,
  output logic [6:0] pcLatchOut,
  output logic [7:0] intCtlOut,
  output logic [7:0] statusOut
);

  logic accept;
  logic isIndirect;
  logic toPm;
  logic nested;
  logic remapBank;
  logic inCore;
  logic inPer;
  logic inRam;
  logic inCom;
  logic [15:0] ptr;
  logic [11:0] effAddr;
  logic [4:0] effBank;
  logic [6:0] effOff;
  logic isSub;
  logic [7:0] bOp;
  logic [7:0] aluRes;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic aluZ;
  logic aluDigit;
  logic aluC;
  logic affZ;
  logic affDigit;
  logic affC;
  logic [7:0] coreRd;
  logic [7:0] readVal;
  logic memWe;
  logic [11:0] ramIdx;
  logic [3:0] comIdx;
  logic [7:0] ramMem [bdmc_pkg::RAM_TOTAL];
  logic [7:0] comMem [bdmc_pkg::COMMON_BYTES];

  bdmc_pkg::bdmc_state_e stateQ, stateD;
  logic rspValidQ, rspValidD;
  logic [7:0] rspDataQ, rspDataD;
  logic pmReadQ, pmReadD;
  logic [14:0] pmAddrQ, pmAddrD;
  logic pmToWQ, pmToWD;
  logic [7:0] pcLowQ, pcLowD;
  logic [4:0] statQ, statD;
  logic [7:0] ptr0lQ, ptr0lD;
  logic [7:0] ptr0hQ, ptr0hD;
  logic [7:0] ptr1lQ, ptr1lD;
  logic [7:0] ptr1hQ, ptr1hD;
  logic [4:0] bankQ, bankD;
  logic [7:0] accQ, accD;
  logic [6:0] pcLatchQ, pcLatchD;
  logic [7:0] intCtlQ, intCtlD;

  // Requests only taken outside the program memory wait
  assign reqReady = (stateQ == bdmc_pkg::ST_IDLE);

  // Address formation and region decode
  always_comb begin
    accept = reqValid && reqReady;
    isIndirect = (reqOffset == bdmc_pkg::OFF_IND_PORT0) || (reqOffset == bdmc_pkg::OFF_IND_PORT1);
    ptr = reqOffset[0] ? {ptr1hQ, ptr1lQ} : {ptr0hQ, ptr0lQ};
    toPm = isIndirect && ptr[8 + bdmc_pkg::PTR_PM_BIT];
    effAddr = isIndirect ? ptr[11:0] : {bankQ, reqOffset};
    effBank = effAddr[11:7];
    effOff = effAddr[6:0];
    nested = isIndirect && (effOff <= bdmc_pkg::OFF_IND_PORT1);
    remapBank = (effBank >= bdmc_pkg::REMAP_BANK_LO) && (effBank <= bdmc_pkg::REMAP_BANK_HI);
    inCore = effOff <= bdmc_pkg::OFF_INTCTL;
    inCom = effOff >= bdmc_pkg::OFF_COM_LO;
    inPer = !inCore && !inCom && ((effOff <= bdmc_pkg::OFF_PER_HI) || remapBank);
    inRam = !inCore && !inCom && !inPer;
  end

  // Arithmetic and flag results
  always_comb begin
    isSub = (reqOp == bdmc_pkg::OP_SUB);
    bOp = isSub ? ~reqOpB : reqOpB;
    sum9 = {1'b0, reqOpA} + {1'b0, bOp} + {8'h00, isSub};
    sum5 = {1'b0, reqOpA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, isSub};
    aluC = sum9[8];
    aluDigit = sum5[4];
    affZ = 1'b0;
    affDigit = 1'b0;
    affC = 1'b0;
    unique case (reqOp)
      bdmc_pkg::OP_PASS: aluRes = reqOpA;
      bdmc_pkg::OP_SWAP: aluRes = {reqOpA[3:0], reqOpA[7:4]};
      bdmc_pkg::OP_CLR: begin
        aluRes = 8'h00;
        affZ = 1'b1;
      end
      bdmc_pkg::OP_ADD, bdmc_pkg::OP_SUB: begin
        aluRes = sum9[7:0];
        affZ = 1'b1;
        affDigit = 1'b1;
        affC = 1'b1;
      end
      bdmc_pkg::OP_AND: begin
        aluRes = reqOpA & reqOpB;
        affZ = 1'b1;
      end
      bdmc_pkg::OP_IOR: begin
        aluRes = reqOpA | reqOpB;
        affZ = 1'b1;
      end
      bdmc_pkg::OP_XOR: begin
        aluRes = reqOpA ^ reqOpB;
        affZ = 1'b1;
      end
      bdmc_pkg::OP_RLC: begin
        aluRes = {reqOpA[6:0], statQ[bdmc_pkg::ST_C]};
        aluC = reqOpA[7];
        affC = 1'b1;
      end
      bdmc_pkg::OP_RRC: begin
        aluRes = {statQ[bdmc_pkg::ST_C], reqOpA[7:1]};
        aluC = reqOpA[0];
        affC = 1'b1;
      end
      default: aluRes = reqOpA;
    endcase
    aluZ = (aluRes == 8'h00);
  end

  // Read value and peripheral window
  always_comb begin
    unique case (effOff)
      bdmc_pkg::OFF_PC_LOW: coreRd = pcLowQ;
      bdmc_pkg::OFF_STATUS: coreRd = {3'b000, statQ};
      bdmc_pkg::OFF_PTR0L: coreRd = ptr0lQ;
      bdmc_pkg::OFF_PTR0H: coreRd = ptr0hQ;
      bdmc_pkg::OFF_PTR1L: coreRd = ptr1lQ;
      bdmc_pkg::OFF_PTR1H: coreRd = ptr1hQ;
      bdmc_pkg::OFF_BANKSEL: coreRd = {3'b000, bankQ};
      bdmc_pkg::OFF_WACC: coreRd = accQ;
      bdmc_pkg::OFF_PCLATCH: coreRd = {1'b0, pcLatchQ};
      bdmc_pkg::OFF_INTCTL: coreRd = intCtlQ;
      default: coreRd = 8'h00;
    endcase
    comIdx = effOff[3:0];
    ramIdx = {1'b0, effBank, 6'h00} + {3'b000, effBank, 4'h0} + {5'h00, effOff - bdmc_pkg::OFF_RAM_LO};
    if (nested) begin
      readVal = 8'h00;
    end else if (inCore) begin
      readVal = coreRd;
    end else if (inCom) begin
      readVal = comMem[comIdx];
    end else if (inRam) begin
      readVal = ramMem[ramIdx];
    end else begin
      readVal = perRdData;
    end
    perSel = accept && !toPm && !nested && inPer;
    perWrite = perSel && reqWrite;
    perAddr = effAddr;
    perWrData = aluRes;
    memWe = accept && reqWrite && !toPm && !nested && (inRam || inCom);
  end

  // General and common RAM storage
  always_ff @(posedge clk) begin
    if (memWe) begin
      if (inCom) begin
        comMem[comIdx] <= aluRes;
      end else begin
        ramMem[ramIdx] <= aluRes;
      end
    end
  end

  // Next state of core registers and sequencer
  always_comb begin
    stateD = stateQ;
    rspValidD = 1'b0;
    rspDataD = rspDataQ;
    pmReadD = 1'b0;
    pmAddrD = pmAddrQ;
    pmToWD = pmToWQ;
    pcLowD = pcLowQ;
    statD = statQ;
    ptr0lD = ptr0lQ;
    ptr0hD = ptr0hQ;
    ptr1lD = ptr1lQ;
    ptr1hD = ptr1hQ;
    bankD = bankQ;
    accD = accQ;
    pcLatchD = pcLatchQ;
    intCtlD = intCtlQ;
    // Direct or indirect write into a core register
    if (accept && reqWrite && !toPm && !nested && inCore) begin
      unique case (effOff)
        bdmc_pkg::OFF_PC_LOW: pcLowD = aluRes;
        // Flag-updating ops block the write to all three flags
        bdmc_pkg::OFF_STATUS: begin
          if (!(affZ || affDigit || affC)) begin
            statD[2:0] = aluRes[2:0];
          end
        end
        bdmc_pkg::OFF_PTR0L: ptr0lD = aluRes;
        bdmc_pkg::OFF_PTR0H: ptr0hD = aluRes;
        bdmc_pkg::OFF_PTR1L: ptr1lD = aluRes;
        bdmc_pkg::OFF_PTR1H: ptr1hD = aluRes;
        bdmc_pkg::OFF_BANKSEL: bankD = aluRes[4:0];
        bdmc_pkg::OFF_WACC: accD = aluRes;
        bdmc_pkg::OFF_PCLATCH: pcLatchD = aluRes[6:0];
        bdmc_pkg::OFF_INTCTL: intCtlD = aluRes & bdmc_pkg::MASK_INTCTL;
        default: ;
      endcase
    end
    // Flag results take precedence over a written value
    if (accept && affZ) begin
      statD[bdmc_pkg::ST_Z] = aluZ;
    end
    if (accept && affDigit) begin
      statD[bdmc_pkg::ST_DIGIT] = aluDigit;
    end
    if (accept && affC) begin
      statD[bdmc_pkg::ST_C] = aluC;
    end
    // Reset cause events; sleep and timeout win ties
    if (dogClearEvt) begin
      statD[bdmc_pkg::ST_TIMEOUT] = 1'b1;
      statD[bdmc_pkg::ST_PWRDN] = 1'b1;
    end
    if (sleepEvt) begin
      statD[bdmc_pkg::ST_TIMEOUT] = 1'b1;
      statD[bdmc_pkg::ST_PWRDN] = 1'b0;
    end
    if (dogTimeoutEvt) begin
      statD[bdmc_pkg::ST_TIMEOUT] = 1'b0;
    end
    // Request sequencing
    unique case (stateQ)
      bdmc_pkg::ST_IDLE: begin
        if (accept) begin
          if (toPm) begin
            pmReadD = 1'b1;
            pmAddrD = ptr[14:0];
            pmToWD = reqToW && !reqWrite;
            stateD = bdmc_pkg::ST_PMWAIT;
          end else begin
            rspValidD = 1'b1;
            rspDataD = readVal;
            if (reqToW && !reqWrite) begin
              accD = readVal;
            end
          end
        end
      end
      bdmc_pkg::ST_PMWAIT: begin
        rspValidD = 1'b1;
        rspDataD = pmData[7:0];
        if (pmToWQ) begin
          accD = pmData[7:0];
        end
        stateD = bdmc_pkg::ST_IDLE;
      end
    endcase
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (reset) begin
      stateQ <= bdmc_pkg::ST_IDLE;
      rspValidQ <= 1'b0;
      rspDataQ <= bdmc_pkg::RST_BYTE;
      pmReadQ <= 1'b0;
      pmAddrQ <= 15'h0000;
      pmToWQ <= 1'b0;
      pcLowQ <= bdmc_pkg::RST_BYTE;
      statQ <= bdmc_pkg::RST_STATUS;
      ptr0lQ <= bdmc_pkg::RST_BYTE;
      ptr0hQ <= bdmc_pkg::RST_BYTE;
      ptr1lQ <= bdmc_pkg::RST_BYTE;
      ptr1hQ <= bdmc_pkg::RST_BYTE;
      bankQ <= 5'h00;
      accQ <= bdmc_pkg::RST_BYTE;
      pcLatchQ <= 7'h00;
      intCtlQ <= bdmc_pkg::RST_INTCTL;
    end else begin
      stateQ <= stateD;
      rspValidQ <= rspValidD;
      rspDataQ <= rspDataD;
      pmReadQ <= pmReadD;
      pmAddrQ <= pmAddrD;
      pmToWQ <= pmToWD;
      pcLowQ <= pcLowD;
      statQ <= statD;
      ptr0lQ <= ptr0lD;
      ptr0hQ <= ptr0hD;
      ptr1lQ <= ptr1lD;
      ptr1hQ <= ptr1hD;
      bankQ <= bankD;
      accQ <= accD;
      pcLatchQ <= pcLatchD;
      intCtlQ <= intCtlD;
    end
  end

  // Output views
  assign rspValid = rspValidQ;
  assign rspData = rspDataQ;
  assign pmRead = pmReadQ;
  assign pmAddr = pmAddrQ;
  assign accOut = accQ;
  assign bankOut = bankQ;
  assign pcLowOut = pcLowQ;
  assign pcLatchOut = pcLatchQ;
  assign intCtlOut = intCtlQ;
  assign statusOut = {3'b000, statQ};

  // Program memory answer comes two cycles after accept
  chk_pm_latency: assert property (@(posedge clk) disable iff (reset)
    accept && toPm |=> !rspValid && pmRead ##1 rspValid)
    else $error("program memory answer not two cycles after accept");

  // Data memory answer comes one cycle after accept
  chk_dm_latency: assert property (@(posedge clk) disable iff (reset)
    accept && !toPm |=> rspValid && !pmRead)
    else $error("data memory answer not one cycle after accept");

  // Answer carries the low byte of the program word
  chk_pm_lowbyte: assert property (@(posedge clk) disable iff (reset)
    pmRead |=> rspData == $past(pmData[7:0]) && rspValid)
    else $error("program word low byte not returned");

  // Program memory address follows the pointer
  chk_pm_address: assert property (@(posedge clk) disable iff (reset)
    accept && toPm |=> pmAddr == $past(ptr[14:0]))
    else $error("program memory address mismatch");

  // No storage write while targeting program memory
  chk_pm_nowrite: assert property (@(posedge clk) disable iff (reset)
    accept && toPm |-> !memWe && !perSel ##1 $stable(ptr0lQ) && $stable(bankQ) && $stable(accQ))
    else $error("write reached storage through program pointer");

  // Direct addresses carry the selected bank
  chk_bank_select: assert property (@(posedge clk) disable iff (reset)
    accept && !isIndirect |-> effBank == bankOut && effOff == reqOffset)
    else $error("direct access not in selected bank");

  // Upper flag bits always zero
  chk_status_upper: assert property (@(posedge clk) disable iff (reset)
    statusOut[7:5] == 3'b000)
    else $error("unimplemented flag bits not zero");

  // Reset cause flags immune to writes
  chk_flag_protect: assert property (@(posedge clk) disable iff (reset)
    accept && reqWrite && !dogClearEvt && !sleepEvt && !dogTimeoutEvt |=> $stable(statusOut[4:3]))
    else $error("reset cause flags changed by a write");

  // Zero flag follows the result, even over a flags write
  chk_zero_flag: assert property (@(posedge clk) disable iff (reset)
    accept && affZ |=> statusOut[bdmc_pkg::ST_Z] == ($past(aluRes) == 8'h00))
    else $error("zero flag does not follow result");

  // Add carry is the ninth sum bit
  chk_add_carry: assert property (@(posedge clk) disable iff (reset)
    accept && reqOp == bdmc_pkg::OP_ADD |=>
      statusOut[0] == $past(({1'b0, reqOpA} + {1'b0, reqOpB}) > 9'h0FF))
    else $error("carry wrong after add");

  // Subtract carry is the inverted borrow
  chk_sub_borrow: assert property (@(posedge clk) disable iff (reset)
    accept && reqOp == bdmc_pkg::OP_SUB |=>
      statusOut[0] == $past(reqOpA >= reqOpB) && statusOut[1] == $past(reqOpA[3:0] >= reqOpB[3:0]))
    else $error("borrow polarity wrong after subtract");

  // Rotate left loads carry from the top bit
  chk_rotate_carry: assert property (@(posedge clk) disable iff (reset)
    accept && reqOp == bdmc_pkg::OP_RLC |=> statusOut[0] == $past(reqOpA[7]))
    else $error("rotate carry not from shifted bit");

  // Timeout and powerdown event effects
  chk_timeout_clear: assert property (@(posedge clk) disable iff (reset)
    dogTimeoutEvt |=> !statusOut[bdmc_pkg::ST_TIMEOUT])
    else $error("timeout flag not cleared");

  chk_sleep_pd: assert property (@(posedge clk) disable iff (reset)
    sleepEvt && !dogTimeoutEvt |=> !statusOut[bdmc_pkg::ST_PWRDN] && statusOut[bdmc_pkg::ST_TIMEOUT])
    else $error("sleep did not set flags");

  // Nested indirect reads return zero
  chk_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
    accept && nested && !toPm |=> rspValid && rspData == 8'h00)
    else $error("unimplemented location read nonzero");

endmodule

// >>> sim/bdmc_far_side.sv
`timescale 1ns/1ps
module bdmc_far_side (
  // Clock
  input wire logic clk,
  // Program memory read port
  input wire logic pmRead,
  input wire logic [14:0] pmAddr,
  output logic [13:0] pmData,
  // Peripheral control register window
  input wire logic perSel,
  input wire logic perWrite,
  input wire logic [11:0] perAddr,
  input wire logic [7:0] perWrData,
  output logic [7:0] perRdData
);
  logic [7:0] noise_q = 8'hA5;
  logic [7:0] lastWr_q = 8'h00;

  // Shifting pattern so stale lines never look valid
  always_ff @(posedge clk) begin
    noise_q <= {noise_q[6:0], noise_q[7] ^ noise_q[5]};
    if (perSel && perWrite) begin
      lastWr_q <= perWrData;
    end
  end

  // Word valid only in the read cycle; upper bits differ from low byte
  assign pmData = pmRead ? {pmAddr[13:8] ^ 6'h15, pmAddr[7:0] ^ 8'h5A} : {noise_q[5:0], ~noise_q};
  // Read data valid only while selected
  assign perRdData = perSel ? (perAddr[7:0] ^ {perAddr[11:8], 4'h3}) : ~noise_q;
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  // Stimulus
  logic clk;
  logic reset;
  logic reqValid;
  logic reqWrite;
  logic reqToW;
  logic [6:0] reqOffset;
  bdmc_pkg::bdmc_op_e reqOp;
  logic [7:0] reqOpA;
  logic [7:0] reqOpB;
  logic dogClearEvt;
  logic sleepEvt;
  logic dogTimeoutEvt;
  // Observed
  logic reqReady;
  logic rspValid;
  logic [7:0] rspData;
  logic pmRead;
  logic [14:0] pmAddr;
  logic [13:0] pmData;
  logic perSel;
  logic perWrite;
  logic [11:0] perAddr;
  logic [7:0] perWrData;
  logic [7:0] perRdData;
  logic [7:0] accOut;
  logic [4:0] bankOut;
  logic [7:0] pcLowOut;
  logic [6:0] pcLatchOut;
  logic [7:0] intCtlOut;
  logic [7:0] statusOut;
  // Bookkeeping
  logic [7:0] rd;
  logic [7:0] lat;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  bdmc_regs u_bdmc_regs (
    .clk(clk), .reset(reset), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqToW(reqToW),
    .reqOffset(reqOffset), .reqOp(reqOp), .reqOpA(reqOpA), .reqOpB(reqOpB), .rspValid(rspValid),
    .rspData(rspData), .pmRead(pmRead), .pmAddr(pmAddr), .pmData(pmData), .perSel(perSel),
    .perWrite(perWrite), .perAddr(perAddr), .perWrData(perWrData), .perRdData(perRdData),
    .dogClearEvt(dogClearEvt), .sleepEvt(sleepEvt), .dogTimeoutEvt(dogTimeoutEvt), .accOut(accOut),
    .bankOut(bankOut), .pcLowOut(pcLowOut), .pcLatchOut(pcLatchOut), .intCtlOut(intCtlOut),
    .statusOut(statusOut)
  );

  bdmc_far_side u_bdmc_far_side (
    .clk(clk), .pmRead(pmRead), .pmAddr(pmAddr), .pmData(pmData), .perSel(perSel), .perWrite(perWrite),
    .perAddr(perAddr), .perWrData(perWrData), .perRdData(perRdData)
  );

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      wrap_up();
    end
  end

  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held for one cycle, then wait for its answer
  task automatic acc(input logic w, input logic [6:0] off, input bdmc_pkg::bdmc_op_e op, input logic [7:0] a,
                     input logic [7:0] b, input logic toW);
    reqValid = 1'b1;
    reqWrite = w;
    reqToW = toW;
    reqOffset = off;
    reqOp = op;
    reqOpA = a;
    reqOpB = b;
    lat = 8'h01;
    @(negedge clk);
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && lat < 8'h08) begin
      @(negedge clk);
      lat = lat + 8'h01;
    end
    rd = rspData;
    @(negedge clk);
  endtask

  task automatic wr(input logic [6:0] off, input logic [7:0] v);
    acc(1'b1, off, bdmc_pkg::OP_PASS, v, 8'h00, 1'b0);
  endtask

  task automatic rdb(input logic [6:0] off);
    acc(1'b0, off, bdmc_pkg::OP_PASS, 8'h00, 8'h00, 1'b0);
  endtask

  // Expected flags of add or subtract
  function automatic logic [2:0] flg(input logic sub, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    return {s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  task automatic arith(input logic sub, input logic [7:0] a, input logic [7:0] b);
    acc(1'b1, 7'h21, sub ? bdmc_pkg::OP_SUB : bdmc_pkg::OP_ADD, a, b, 1'b0);
    chk("flags", {5'h00, statusOut[2:0]}, {5'h00, flg(sub, a, b)});
  endtask

  task automatic rot(input bdmc_pkg::bdmc_op_e op, input logic [7:0] a, input logic c);
    acc(1'b1, 7'h21, op, a, 8'h00, 1'b0);
    chk("carry", {7'h00, statusOut[0]}, {7'h00, c});
  endtask

  // Event pulse, then reset-cause flags
  task automatic ev(input logic [2:0] e, input logic [1:0] exp);
    {dogClearEvt, sleepEvt, dogTimeoutEvt} = e;
    @(negedge clk);
    {dogClearEvt, sleepEvt, dogTimeoutEvt} = 3'b000;
    chk("cause", {6'h00, statusOut[4:3]}, {6'h00, exp});
  endtask

  task automatic t_reset();
    chk("status", statusOut, 8'h18);
    chk("bank", {3'h0, bankOut}, 8'h00);
    chk("int ctl", intCtlOut, 8'h01);
    $display("test reset done");
  endtask

  task automatic t_status();
    wr(7'h03, 8'hFF);
    chk("status", statusOut, 8'h1F);
    wr(7'h03, 8'h03);
    chk("status", statusOut, 8'h1B);
    acc(1'b1, 7'h03, bdmc_pkg::OP_CLR, 8'h00, 8'h00, 1'b0);
    chk("status", statusOut, 8'h1F);
    acc(1'b1, 7'h03, bdmc_pkg::OP_ADD, 8'h01, 8'h01, 1'b0);
    chk("status", statusOut, 8'h18);
    rdb(7'h03);
    chk("status rd", rd, 8'h18);
    $display("test status done");
  endtask

  task automatic t_events();
    ev(3'b010, 2'b10);
    ev(3'b001, 2'b00);
    ev(3'b100, 2'b11);
    ev(3'b110, 2'b10);
    ev(3'b101, 2'b01);
    $display("test events done");
  endtask

  task automatic t_banks();
    wr(7'h08, 8'h05);
    chk("bank", {3'h0, bankOut}, 8'h05);
    wr(7'h20, 8'h11);
    wr(7'h70, 8'h77);
    wr(7'h08, 8'h06);
    wr(7'h20, 8'h22);
    rdb(7'h20);
    chk("ram", rd, 8'h22);
    wr(7'h08, 8'h1F);
    rdb(7'h70);
    chk("common", rd, 8'h77);
    wr(7'h09, 8'h3C);
    chk("wacc", accOut, 8'h3C);
    wr(7'h08, 8'h05);
    rdb(7'h20);
    chk("ram", rd, 8'h11);
    wr(7'h08, 8'hFF);
    rdb(7'h08);
    chk("bank rd", rd, 8'h1F);
    wr(7'h0A, 8'hFF);
    rdb(7'h0A);
    chk("latch rd", rd, 8'h7F);
    $display("test banks done");
  endtask

  task automatic t_periph();
    wr(7'h08, 8'h02);
    rdb(7'h0C);
    chk("periph", rd, 8'h0C ^ 8'h13);
    wr(7'h1F, 8'h9D);
    chk("periph wr", u_bdmc_far_side.lastWr_q, 8'h9D);
    wr(7'h08, 8'h1C);
    rdb(7'h30);
    chk("remap bank", rd, 8'h30 ^ 8'hE3);
    $display("test periph done");
  endtask

  task automatic t_indirect();
    wr(7'h08, 8'h04);
    wr(7'h34, 8'h5E);
    wr(7'h04, 8'hA5);
    wr(7'h05, 8'h01);
    wr(7'h00, 8'h4B);
    chk("lat data", lat, 8'h01);
    wr(7'h08, 8'h03);
    rdb(7'h25);
    chk("via ptr", rd, 8'h4B);
    wr(7'h06, 8'h34);
    wr(7'h07, 8'hD2);
    acc(1'b0, 7'h01, bdmc_pkg::OP_PASS, 8'h00, 8'h00, 1'b1);
    chk("pm rd", rd, 8'h6E);
    chk("lat pm", lat, 8'h02);
    chk("wacc", accOut, 8'h6E);
    wr(7'h01, 8'hC3);
    chk("lat pm wr", lat, 8'h02);
    wr(7'h08, 8'h04);
    rdb(7'h34);
    chk("no store", rd, 8'h5E);
    wr(7'h04, 8'h01);
    wr(7'h05, 8'h00);
    rdb(7'h00);
    chk("nested", rd, 8'h00);
    $display("test indirect done");
  endtask

  task automatic t_flags();
    arith(1'b0, 8'h0F, 8'h01);
    rdb(7'h21);
    chk("sum", rd, 8'h10);
    arith(1'b0, 8'hFF, 8'h01);
    arith(1'b1, 8'h05, 8'h05);
    arith(1'b1, 8'h10, 8'h01);
    rdb(7'h21);
    chk("diff", rd, 8'h0F);
    arith(1'b1, 8'h00, 8'h01);
    rot(bdmc_pkg::OP_RLC, 8'h80, 1'b1);
    rot(bdmc_pkg::OP_RRC, 8'h02, 1'b0);
    rot(bdmc_pkg::OP_RRC, 8'h01, 1'b1);
    acc(1'b1, 7'h21, bdmc_pkg::OP_AND, 8'hF0, 8'h0F, 1'b0);
    chk("zero", {7'h00, statusOut[2]}, 8'h01);
    acc(1'b1, 7'h21, bdmc_pkg::OP_IOR, 8'h01, 8'h00, 1'b0);
    chk("zero", {7'h00, statusOut[2]}, 8'h00);
    $display("test flags done");
  endtask

  // Counts and verdict
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqToW = 1'b0;
    reqOffset = 7'h00;
    reqOp = bdmc_pkg::OP_PASS;
    reqOpA = 8'h00;
    reqOpB = 8'h00;
    dogClearEvt = 1'b0;
    sleepEvt = 1'b0;
    dogTimeoutEvt = 1'b0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_status();
    t_events();
    t_banks();
    t_periph();
    t_indirect();
    t_flags();
    wrap_up();
  end
endmodule
